//--- design/aoc_regs.svh
`ifndef AOC_REGS_SVH
`define AOC_REGS_SVH

// ----------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------
`define AOC_ADDR_W 5
`define AOC_DATA_W 11
`define AOC_FRAME_BITS 5'h10

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AOC_OFS_POWER_INTERFACE 5'h00
`define AOC_OFS_OUTPUT_TIMING 5'h04
`define AOC_OFS_DDR_ORDERING 5'h09
`define AOC_OFS_FORMAT_PATTERN 5'h0a
`define AOC_OFS_USER_PATTERN_LOW 5'h0b
`define AOC_OFS_GAIN_PATTERN_HIGH 5'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AOC_POS_STANDBY 0
`define AOC_POS_PDN_CLKOUT 2
`define AOC_POS_SOFT_RESET 4
`define AOC_POS_EXT_REF 5
`define AOC_POS_LVDS_MODE 8
`define AOC_POS_COARSE_GAIN 9
`define AOC_POS_PDN_OUTBUF 10
`define AOC_POS_CLK_SHIFT 8
`define AOC_POS_CAPTURE_EDGE 9
`define AOC_POS_DATA_SHIFT 10
`define AOC_POS_BYTE_WISE 10
`define AOC_POS_NUMBER_CODING 10
`define AOC_POS_PATTERN_HI 7
`define AOC_POS_PATTERN_LO 5
`define AOC_POS_CUSTOM_LOW_HI 10
`define AOC_POS_CUSTOM_LOW_LO 4
`define AOC_POS_CUSTOM_HIGH_HI 4
`define AOC_POS_CUSTOM_HIGH_LO 0
`define AOC_POS_FINE_GAIN_HI 10
`define AOC_POS_FINE_GAIN_LO 8

// ----------------------------------------------------------------
// Pattern codes and values
// ----------------------------------------------------------------
`define AOC_PAT_LIVE 3'h0
`define AOC_PAT_ZEROS 3'h1
`define AOC_PAT_ONES 3'h2
`define AOC_PAT_TOGGLE 3'h3
`define AOC_PAT_RAMP 3'h4
`define AOC_PAT_CUSTOM 3'h5
`define AOC_WORD_ZEROS 12'h000
`define AOC_WORD_ONES 12'hfff
`define AOC_WORD_TOGGLE_A 12'haaa
`define AOC_WORD_TOGGLE_B 12'h555
`define AOC_WORD_MIDSCALE 12'h800

// ----------------------------------------------------------------
// Fine gain coefficients, unity is 1024
// ----------------------------------------------------------------
`define AOC_GAIN_FRAC_BITS 10
`define AOC_GAIN_0DB 12'h400
`define AOC_GAIN_1DB 12'h47d
`define AOC_GAIN_2DB 12'h509
`define AOC_GAIN_3DB 12'h5a7
`define AOC_GAIN_4DB 12'h657
`define AOC_GAIN_5DB 12'h71d
`define AOC_GAIN_6DB 12'h7fb

`endif

//--- design/aoc_pkg.sv
`default_nettype none

package aoc_pkg;

  // Programmed fields of the control registers
  typedef struct packed {
    logic standby;
    logic pdn_clkout;
    logic ext_ref;
    logic lvds_mode;
    logic coarse_gain;
    logic pdn_outbuf;
    logic clk_shift;
    logic capture_edge;
    logic data_shift;
    logic byte_wise;
    logic number_coding;
    logic [2:0] pattern_sel;
    logic [11:0] custom_word;
    logic [2:0] fine_gain;
  } aoc_cfg_type;

  // Serial port receiver state
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_prev;
    logic sen_n_s1;
    logic sen_n_s2;
    logic sen_n_prev;
    logic sdata_s1;
    logic sdata_s2;
    logic [15:0] shift;
    logic [4:0] count;
    logic wr_valid;
    logic [4:0] wr_addr;
    logic [10:0] wr_data;
  } aoc_spi_type;

  // Pattern generator state
  typedef struct packed {
    logic [11:0] ramp;
    logic toggle;
    logic [11:0] word;
  } aoc_pat_type;

endpackage

`default_nettype wire

//--- design/aoc_serial_port.sv
`include "aoc_regs.svh"
`default_nettype none

module aoc_serial_port
  import aoc_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sclk_in,
  input wire logic sen_n_in,
  input wire logic sdata_in,
  output logic wr_valid_out,
  output logic [4:0] wr_addr_out,
  output logic [10:0] wr_data_out
);

  aoc_spi_type st_r;
  aoc_spi_type st_nxt;

  // Sample pins, shift bits on serial clock rise, commit on enable rise
  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_s1 = sclk_in;
    st_nxt.sclk_s2 = st_r.sclk_s1;
    st_nxt.sclk_prev = st_r.sclk_s2;
    st_nxt.sen_n_s1 = sen_n_in;
    st_nxt.sen_n_s2 = st_r.sen_n_s1;
    st_nxt.sen_n_prev = st_r.sen_n_s2;
    st_nxt.sdata_s1 = sdata_in;
    st_nxt.sdata_s2 = st_r.sdata_s1;
    st_nxt.wr_valid = 1'b0;
    if (st_r.sen_n_s2 && !st_r.sen_n_prev) begin
      if (st_r.count >= `AOC_FRAME_BITS) begin
        st_nxt.wr_valid = 1'b1;
        st_nxt.wr_addr = st_r.shift[15:11];
        st_nxt.wr_data = st_r.shift[10:0];
      end
    end
    if (st_r.sen_n_s2) begin
      st_nxt.count = 5'h00;
    end else if (st_r.sclk_s2 && !st_r.sclk_prev) begin
      st_nxt.shift = {st_r.shift[14:0], st_r.sdata_s2};
      if (st_r.count < `AOC_FRAME_BITS) begin
        st_nxt.count = st_r.count + 5'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '{sen_n_s1: 1'b1, sen_n_s2: 1'b1, sen_n_prev: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wr_valid_out = st_r.wr_valid;
  assign wr_addr_out = st_r.wr_addr;
  assign wr_data_out = st_r.wr_data;

endmodule

`default_nettype wire

//--- design/aoc_pattern_gen.sv
`include "aoc_regs.svh"
`default_nettype none

module aoc_pattern_gen
  import aoc_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sample_strobe_in,
  input wire logic [2:0] pattern_sel_in,
  input wire logic [11:0] custom_word_in,
  input wire logic [11:0] live_word_in,
  output logic [11:0] pattern_word_out
);

  aoc_pat_type st_r;
  aoc_pat_type st_nxt;

  // Choose one word per sample
  always_comb begin
    st_nxt = st_r;
    if (pattern_sel_in != `AOC_PAT_RAMP) begin
      st_nxt.ramp = `AOC_WORD_ZEROS;
    end
    if (pattern_sel_in != `AOC_PAT_TOGGLE) begin
      st_nxt.toggle = 1'b0;
    end
    if (sample_strobe_in) begin
      unique case (pattern_sel_in)
        `AOC_PAT_ZEROS: st_nxt.word = `AOC_WORD_ZEROS;
        `AOC_PAT_ONES: st_nxt.word = `AOC_WORD_ONES;
        `AOC_PAT_TOGGLE: begin
          st_nxt.word = st_r.toggle ? `AOC_WORD_TOGGLE_B : `AOC_WORD_TOGGLE_A;
          st_nxt.toggle = !st_r.toggle;
        end
        `AOC_PAT_RAMP: begin
          st_nxt.word = st_r.ramp;
          st_nxt.ramp = st_r.ramp + 12'h001;
        end
        `AOC_PAT_CUSTOM: st_nxt.word = custom_word_in;
        default: st_nxt.word = live_word_in;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pattern_word_out = st_r.word;

endmodule

`default_nettype wire

//--- design/aoc_top.sv
// Overview of operation
// - Standby bit powers down conversion core only
// - Clock power-down tristates clock, data unchanged
// - Software reset restores defaults, then self-clears
// - Interface bit picks CMOS or DDR LVDS
// - Output power-down disables data and clock
// - Clock position bit delays clock 400 ps
// - Edge bit picks receiver capture clock edge
// - Data position bit delays data half cycle
// - Bit-wise: even bits rising, odd falling
// - Byte-wise: lower group rising, upper falling
// - Coding bit picks two's complement or binary
// - Pattern 000 passes live conversion result
// - Patterns 001/010 give all zeros, ones; in two's complement coding pins show 0x800, 0x7FF
// - Pattern 011 alternates 0xAAA and 0x555; in two's complement coding pins show 0x2AA, 0xD55
// - Pattern 100 ramps up one per sample
// - Pattern 101 sends custom word, MSB inverted in two's complement coding; 110/111 unused
// - Register 0B D10-D4 hold custom low bits
// - Register 0C D4-D0 hold custom high bits
// - Fine gain zero to six dB, steps
`include "aoc_regs.svh"
`default_nettype none

module aoc_top
  import aoc_pkg::*;
#(
  parameter int SAMPLE_W = 12,
  parameter int LANES = 6
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sclk_in,
  input wire logic sen_n_in,
  input wire logic sdata_in,
  input wire logic [SAMPLE_W-1:0] adc_sample_in,
  output logic [SAMPLE_W-1:0] sample_word_out,
  output logic data_oe_out,
  output logic output_clock_pos_out,
  output logic clk_oe_out,
  output logic clk_shift_out,
  output logic core_standby_out,
  output logic coarse_gain_out,
  output logic ext_ref_out,
  output logic lvds_mode_out
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef struct packed {
    aoc_cfg_type cfg;
    logic phase;
    logic coding;
    logic [SAMPLE_W-1:0] early;
    logic [SAMPLE_W-1:0] data_out;
    logic data_oe;
    logic clk_out;
    logic clk_oe;
    logic clk_shift;
    logic standby;
    logic coarse_gain;
    logic ext_ref;
    logic lvds_mode;
  } aoc_top_type;

  aoc_top_type st_r;
  aoc_top_type st_nxt;

  logic wr_valid;
  logic [4:0] wr_addr;
  logic [10:0] wr_data;
  logic [SAMPLE_W-1:0] live_word;
  logic [SAMPLE_W-1:0] pattern_word;
  logic sample_strobe;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Fine gain code to coefficient; unused code gives unity
  function automatic logic [11:0] gain_coef(input logic [2:0] code);
    logic [11:0] coef;
    unique case (code)
      3'h1: coef = `AOC_GAIN_1DB;
      3'h2: coef = `AOC_GAIN_2DB;
      3'h3: coef = `AOC_GAIN_3DB;
      3'h4: coef = `AOC_GAIN_4DB;
      3'h5: coef = `AOC_GAIN_5DB;
      3'h6: coef = `AOC_GAIN_6DB;
      default: coef = `AOC_GAIN_0DB;
    endcase
    return coef;
  endfunction

  // Picks one lane group out of a word for one clock half
  function automatic logic [LANES-1:0] lane_group(
    input logic [SAMPLE_W-1:0] word,
    input logic byte_wise,
    input logic upper
  );
    logic [LANES-1:0] grp;
    grp = '0;
    for (int i = 0; i < LANES; i++) begin
      if (byte_wise) begin
        grp[i] = word[i + (upper ? LANES : 0)];
      end else begin
        grp[i] = word[2 * i + (upper ? 1 : 0)];
      end
    end
    return grp;
  endfunction

  // ----------------------------------------------------------------
  // Serial programming port
  // ----------------------------------------------------------------
  aoc_serial_port u_serial (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sclk_in(sclk_in),
    .sen_n_in(sen_n_in),
    .sdata_in(sdata_in),
    .wr_valid_out(wr_valid),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data)
  );

  // ----------------------------------------------------------------
  // Live sample path with fine gain
  // ----------------------------------------------------------------
  logic signed [SAMPLE_W-1:0] live_signed;
  logic signed [SAMPLE_W+12:0] live_prod;
  logic signed [SAMPLE_W+12:0] live_scaled;
  logic signed [SAMPLE_W-1:0] live_sat;

  always_comb begin
    live_signed = $signed({~adc_sample_in[SAMPLE_W-1], adc_sample_in[SAMPLE_W-2:0]});
    live_prod = live_signed * $signed({1'b0, gain_coef(st_r.cfg.fine_gain)});
    live_scaled = live_prod >>> `AOC_GAIN_FRAC_BITS;
    if (live_scaled > $signed({{14{1'b0}}, {(SAMPLE_W-1){1'b1}}})) begin
      live_sat = {1'b0, {(SAMPLE_W-1){1'b1}}};
    end else if (live_scaled < -$signed({{13{1'b0}}, 1'b1, {(SAMPLE_W-1){1'b0}}})) begin
      live_sat = {1'b1, {(SAMPLE_W-1){1'b0}}};
    end else begin
      live_sat = live_scaled[SAMPLE_W-1:0];
    end
  end

  assign live_word = st_r.cfg.standby ? `AOC_WORD_MIDSCALE
                                      : {~live_sat[SAMPLE_W-1], live_sat[SAMPLE_W-2:0]};

  // New sample at the start of each output clock period
  assign sample_strobe = !st_r.phase;

  // ----------------------------------------------------------------
  // Test pattern source
  // ----------------------------------------------------------------
  // pattern replaces sample word
  aoc_pattern_gen u_pattern (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .sample_strobe_in(sample_strobe),
    .pattern_sel_in(st_r.cfg.pattern_sel),
    .custom_word_in(st_r.cfg.custom_word),
    .live_word_in(live_word),
    .pattern_word_out(pattern_word)
  );

  // ----------------------------------------------------------------
  // Register writes and output formatting
  // ----------------------------------------------------------------
  logic [SAMPLE_W-1:0] coded_word;
  logic [SAMPLE_W-1:0] drive_word;

  // output number coding, switched only with a new sample
  assign coded_word = st_r.coding ? pattern_word
                                             : {~pattern_word[SAMPLE_W-1],
                                                pattern_word[SAMPLE_W-2:0]};

  // Next state of registers and pins
  always_comb begin
    st_nxt = st_r;

    if (wr_valid) begin
      unique case (wr_addr)
        `AOC_OFS_POWER_INTERFACE: begin
          st_nxt.cfg.standby = wr_data[`AOC_POS_STANDBY];
          st_nxt.cfg.pdn_clkout = wr_data[`AOC_POS_PDN_CLKOUT];
          st_nxt.cfg.ext_ref = wr_data[`AOC_POS_EXT_REF];
          st_nxt.cfg.lvds_mode = wr_data[`AOC_POS_LVDS_MODE];
          st_nxt.cfg.coarse_gain = wr_data[`AOC_POS_COARSE_GAIN];
          st_nxt.cfg.pdn_outbuf = wr_data[`AOC_POS_PDN_OUTBUF];
          if (wr_data[`AOC_POS_SOFT_RESET]) begin
            st_nxt.cfg = '0;
          end
        end
        `AOC_OFS_OUTPUT_TIMING: begin
          st_nxt.cfg.clk_shift = wr_data[`AOC_POS_CLK_SHIFT];
          st_nxt.cfg.capture_edge = wr_data[`AOC_POS_CAPTURE_EDGE];
          st_nxt.cfg.data_shift = wr_data[`AOC_POS_DATA_SHIFT];
        end
        `AOC_OFS_DDR_ORDERING: begin
          st_nxt.cfg.byte_wise = wr_data[`AOC_POS_BYTE_WISE];
        end
        `AOC_OFS_FORMAT_PATTERN: begin
          st_nxt.cfg.number_coding = wr_data[`AOC_POS_NUMBER_CODING];
          st_nxt.cfg.pattern_sel = wr_data[`AOC_POS_PATTERN_HI:`AOC_POS_PATTERN_LO];
        end
        `AOC_OFS_USER_PATTERN_LOW: begin
          st_nxt.cfg.custom_word[6:0] =
            wr_data[`AOC_POS_CUSTOM_LOW_HI:`AOC_POS_CUSTOM_LOW_LO];
        end
        `AOC_OFS_GAIN_PATTERN_HIGH: begin
          st_nxt.cfg.custom_word[11:7] =
            wr_data[`AOC_POS_CUSTOM_HIGH_HI:`AOC_POS_CUSTOM_HIGH_LO];
          st_nxt.cfg.fine_gain = wr_data[`AOC_POS_FINE_GAIN_HI:`AOC_POS_FINE_GAIN_LO];
        end
        default: begin
          // Other addresses are ignored
        end
      endcase
    end

    // Output clock half-cycle phase
    st_nxt.phase = !st_r.phase;
    // Coding follows the sample word, so a word never changes mid-sample
    if (sample_strobe) begin
      st_nxt.coding = st_r.cfg.number_coding;
    end

    // CMOS word or DDR lane groups
    drive_word = coded_word;
    if (st_r.cfg.lvds_mode) begin
      drive_word = '0;
      drive_word[LANES-1:0] = lane_group(coded_word, st_r.cfg.byte_wise, !st_r.phase);
    end

    st_nxt.early = drive_word;
    st_nxt.data_out = st_r.cfg.data_shift ? st_r.early : drive_word;

    st_nxt.clk_out = st_r.phase ^ st_r.cfg.capture_edge;

    st_nxt.data_oe = !st_r.cfg.pdn_outbuf;
    st_nxt.clk_oe = !st_r.cfg.pdn_outbuf && !st_r.cfg.pdn_clkout;

    st_nxt.clk_shift = st_r.cfg.clk_shift;
    st_nxt.standby = st_r.cfg.standby;
    st_nxt.coarse_gain = st_r.cfg.coarse_gain;
    st_nxt.ext_ref = st_r.cfg.ext_ref;
    st_nxt.lvds_mode = st_r.cfg.lvds_mode;
  end

  // State register, hardware reset to defaults
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign sample_word_out = st_r.data_out;
  assign data_oe_out = st_r.data_oe;
  assign output_clock_pos_out = st_r.clk_out;
  assign clk_oe_out = st_r.clk_oe;
  assign clk_shift_out = st_r.clk_shift;
  assign core_standby_out = st_r.standby;
  assign coarse_gain_out = st_r.coarse_gain;
  assign ext_ref_out = st_r.ext_ref;
  assign lvds_mode_out = st_r.lvds_mode;

endmodule

`default_nettype wire

//--- verif/aoc_top_properties.sv
`default_nettype none

module aoc_top_properties #(
  parameter int SAMPLE_W = 12
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sen_n_in,
  input wire logic [SAMPLE_W-1:0] sample_word_out,
  input wire logic data_oe_out,
  input wire logic output_clock_pos_out,
  input wire logic clk_oe_out,
  input wire logic clk_shift_out,
  input wire logic core_standby_out,
  input wire logic coarse_gain_out,
  input wire logic ext_ref_out,
  input wire logic lvds_mode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // --------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------
  sequence wake_s;
    !data_oe_out ##1 (data_oe_out && clk_oe_out);
  endsequence
  sequence clk_flat_s;
    clk_oe_out && $past(clk_oe_out) && $stable(output_clock_pos_out);
  endsequence
  sequence cmos_word_s;
    (!lvds_mode_out && data_oe_out) [*4] ##0 $changed(sample_word_out);
  endsequence

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  // drivers wake after reset
  reset_wake_a: assert property ($rose(resetn_in) |-> wake_s)
    else $error("drivers not enabled after reset");
  oe_pair_a: assert property (!data_oe_out |-> !clk_oe_out)
    else $error("clock driven while data drivers off");
  clk_run_a: assert property (clk_flat_s |=> $changed(output_clock_pos_out))
    else $error("output clock held too long");
  cmos_hold_a: assert property (cmos_word_s |=> $stable(sample_word_out))
    else $error("parallel word stood one cycle only");
  lvds_upper_a: assert property (lvds_mode_out [*4] |->
    sample_word_out[SAMPLE_W-1:6] == '0)
    else $error("upper pins active in lane mode");
  level_commit_a: assert property (($changed(core_standby_out) ||
    $changed(coarse_gain_out) || $changed(ext_ref_out)) |-> $past(sen_n_in, 3))
    else $error("level changed inside a frame");
  iface_commit_a: assert property (($changed(lvds_mode_out) ||
    $changed(clk_shift_out)) |-> $past(sen_n_in, 3))
    else $error("interface changed inside a frame");
  oe_commit_a: assert property (($fell(data_oe_out) ||
    $fell(clk_oe_out)) |-> $past(sen_n_in, 3))
    else $error("driver disabled inside a frame");
endmodule

bind aoc_top aoc_top_properties #(.SAMPLE_W(SAMPLE_W)) i_aoc_top_properties (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .sen_n_in(sen_n_in),
  .sample_word_out(sample_word_out),
  .data_oe_out(data_oe_out),
  .output_clock_pos_out(output_clock_pos_out),
  .clk_oe_out(clk_oe_out),
  .clk_shift_out(clk_shift_out),
  .core_standby_out(core_standby_out),
  .coarse_gain_out(coarse_gain_out),
  .ext_ref_out(ext_ref_out),
  .lvds_mode_out(lvds_mode_out)
);

`default_nettype wire

//--- verif/aoc_rx_model.sv
`default_nettype none

module aoc_rx_model (
  input wire logic clk_in,
  input wire logic [11:0] data_in,
  input wire logic oclk_in,
  input wire logic lvds_in,
  input wire logic byte_in,
  input wire logic edge_in,
  input wire logic shift_in,
  output logic [11:0] word_out,
  output logic valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] first = 6'h00;
  initial word_out = 12'h000;
  initial valid_out = 1'b0;

  // Pair lane groups into words
  // selected capture edge
  always @(posedge clk_in) begin
    valid_out <= 1'b0;
    if ((oclk_in != edge_in) ^ shift_in) begin
      first <= data_in[5:0];
    end else begin
      valid_out <= 1'b1;
      if (!lvds_in) word_out <= data_in;
      else if (byte_in) word_out <= {data_in[5:0], first};
      else for (int i = 0; i < 6; i++) word_out[2*i +: 2] <= {data_in[i], first[i]};
    end
  end
endmodule

`default_nettype wire

//--- verif/aoc_top_tb.sv
`include "aoc_regs.svh"
`default_nettype none

module aoc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic sclk_in = 1'b0;
  logic sen_n_in = 1'b1;
  logic sdata_in = 1'b0;
  logic [11:0] adc_sample_in = 12'h000;
  logic [11:0] sample_word_out, rx_word;
  logic data_oe_out, output_clock_pos_out, clk_oe_out, clk_shift_out, core_standby_out;
  logic coarse_gain_out, ext_ref_out, lvds_mode_out, rx_valid;
  logic lvds = 1'b0, bytew = 1'b0, cap_edge = 1'b0, shift = 1'b0;
  int n_errors = 0;
  int n_tests = 0;

  // Sample clock
  always #25 clk_in = ~clk_in;

  aoc_top i_aoc_top (
    .clk_in(clk_in), .resetn_in(resetn_in), .sclk_in(sclk_in), .sen_n_in(sen_n_in),
    .sdata_in(sdata_in), .adc_sample_in(adc_sample_in), .sample_word_out(sample_word_out),
    .data_oe_out(data_oe_out), .output_clock_pos_out(output_clock_pos_out),
    .clk_oe_out(clk_oe_out), .clk_shift_out(clk_shift_out),
    .core_standby_out(core_standby_out), .coarse_gain_out(coarse_gain_out),
    .ext_ref_out(ext_ref_out), .lvds_mode_out(lvds_mode_out)
  );

  aoc_rx_model i_aoc_rx_model (
    .clk_in(clk_in), .data_in(sample_word_out), .oclk_in(output_clock_pos_out),
    .lvds_in(lvds), .byte_in(bytew), .edge_in(cap_edge), .shift_in(shift),
    .word_out(rx_word), .valid_out(rx_valid)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] coded(input logic [11:0] w, input logic c);
    return c ? w : {~w[11], w[10:0]};
  endfunction

  // Live word under fine gain, two's complement output, saturated
  function automatic logic [11:0] gained(input logic [11:0] a, input logic [11:0] g);
    int p;
    p = ($signed({~a[11], a[10:0]}) * int'(g)) >>> `AOC_GAIN_FRAC_BITS;
    if (p > 2047) p = 2047;
    if (p < -2048) p = -2048;
    return 12'(p);
  endfunction

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Serial frame, MSB first; n below 16 gives a cut frame
  // callers write unused bits as zero, except the unmapped address 5'h05, which gets 11'h7ff
  task automatic wr(input logic [4:0] a, input logic [10:0] d, input int n = 16);
    logic [15:0] f;
    f = {a, d};
    @(negedge clk_in);
    sen_n_in = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      sdata_in = f[i];
      repeat (4) @(negedge clk_in);
      sclk_in = 1'b1;
      repeat (4) @(negedge clk_in);
      sclk_in = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    sen_n_in = 1'b1;
    sdata_in = ~sdata_in;
    repeat (16) @(negedge clk_in);
  endtask

  // Next word from the receiver model
  task automatic rx(output logic [11:0] w);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_in);
      if (rx_valid === 1'b1) break;
    end
    w = rx_word;
    @(negedge clk_in);
  endtask

  // Pattern codes 000 to 101 under both codings
  task automatic pats(input logic [11:0] cw);
    logic [11:0] w1, w2, e;
    for (int c = 0; c < 2; c++) begin
      for (int p = 0; p < 6; p++) begin
        wr(`AOC_OFS_FORMAT_PATTERN, {c[0], 2'b00, p[2:0], 5'h00});
        rx(w1);
        rx(w2);
        case (p)
          0: e = adc_sample_in;
          1: e = `AOC_WORD_ZEROS;
          2: e = `AOC_WORD_ONES;
          default: e = cw;
        endcase
        if (p == 4) check(w2, w1 + 12'h001);
        else if (p == 3) check(w2 ^ w1, 12'hfff);
        else check(w2, coded(e, c[0]));
        if (p == 3) check(12'(w1 === coded(`AOC_WORD_TOGGLE_A, c[0]) ||
          w1 === coded(`AOC_WORD_TOGGLE_B, c[0])), 12'h001);
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [11:0] cw, w;
    void'($urandom(32'h0000_6603));
    repeat (10) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    check(12'({core_standby_out, lvds_mode_out, clk_shift_out, data_oe_out, clk_oe_out}),
      12'h003);
    // Parallel, bit-wise, byte-wise, shifted bit-wise
    for (int m = 0; m < 4; m++) begin
      lvds = (m > 0);
      bytew = (m == 2);
      shift = (m == 3);
      cap_edge = 1'($urandom);
      cw = 12'($urandom);
      adc_sample_in = 12'($urandom);
      wr(`AOC_OFS_POWER_INTERFACE, {2'b00, lvds, 8'h00});
      wr(`AOC_OFS_OUTPUT_TIMING, {shift, cap_edge, 9'h000});
      wr(`AOC_OFS_DDR_ORDERING, {bytew, 10'h000});
      wr(`AOC_OFS_USER_PATTERN_LOW, {cw[6:0], 4'h0});
      wr(`AOC_OFS_GAIN_PATTERN_HIGH, {6'h00, cw[11:7]});
      check(12'(lvds_mode_out), 12'(lvds));
      pats(cw);
    end
    lvds = 1'b0;
    bytew = 1'b0;
    shift = 1'b0;
    cap_edge = 1'b0;
    // Reset bit with standby and lane mode in the same word
    wr(`AOC_OFS_POWER_INTERFACE, 11'h111);
    check(12'({core_standby_out, lvds_mode_out, clk_shift_out, data_oe_out, clk_oe_out}),
      12'h003);
    rx(w);
    rx(w);
    check(w, coded(adc_sample_in, 1'b0));
    // Standby, coarse gain and reference in one write
    wr(`AOC_OFS_POWER_INTERFACE, 11'h221);
    check(12'({core_standby_out, coarse_gain_out, ext_ref_out, data_oe_out}), 12'h00f);
    rx(w);
    rx(w);
    check(w, coded(`AOC_WORD_MIDSCALE, 1'b0));
    // Cut frame and unmapped address change nothing
    wr(`AOC_OFS_POWER_INTERFACE, 11'h000, 10);
    wr(5'h05, 11'h7ff);
    check(12'({core_standby_out, data_oe_out, clk_oe_out}), 12'h007);
    wr(`AOC_OFS_POWER_INTERFACE, 11'h004);
    check(12'({clk_oe_out, data_oe_out, core_standby_out}), 12'h002);
    wr(`AOC_OFS_POWER_INTERFACE, 11'h400);
    check(12'({clk_oe_out, data_oe_out}), 12'h000);
    wr(`AOC_OFS_POWER_INTERFACE, 11'h000);
    wr(`AOC_OFS_OUTPUT_TIMING, 11'h100);
    check(12'({clk_shift_out, data_oe_out, clk_oe_out}), 12'h007);
    // Fine gain of six steps on the live word
    wr(`AOC_OFS_GAIN_PATTERN_HIGH, 11'h600);
    rx(w);
    rx(w);
    check(w, gained(adc_sample_in, `AOC_GAIN_6DB));
    end_sim;
  end

  // Watchdog
  initial begin
    #2_000_000;
    n_errors++;
    end_sim;
  end
endmodule

`default_nettype wire
